//--- quad_wiper_command_decoder_test.sv
// self-checking bench: APB orders to the master, decoder on the far end
// assumes both design ends and the link checker are compiled first
`timescale 1ns/100ps
`include "qwd_cfg.svh"
module quad_wiper_command_decoder_test;
  // ----------------------------------------
  // clock, reset and design
  // ----------------------------------------
  localparam int NV_CYC = 2000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] strap_address_pins = 4'h5;
  logic [3:0][63:0] tap_enable;
  logic [3:0] wiper_off;
  logic [3:0] chain_mode;
  logic nv_busy;
  logic [3:0] tgt = 4'h5;
  logic [31:0] st;
  logic err;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int pos [4] = '{0, 19, 42, 0};

  always #2 pclk = ~pclk;

  qwd_link_if link ();
  qwd_host qwd_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  qwd_device #(.NV_WRITE_CYCLES(NV_CYC)) qwd_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link.dev), .strap_address_pins(strap_address_pins), .tap_enable(tap_enable),
    .wiper_off(wiper_off), .chain_mode(chain_mode), .nv_busy(nv_busy));
  qwd_link_asserts qwd_link_asserts_inst (.pclk(pclk), .presetn(presetn), .scl(link.scl),
    .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic settle();
    repeat (30) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] pot,
    input logic [1:0] rs, input logic [7:0] dat, input logic [1:0] kind, input logic [5:0] stp);
    return {stp, kind, dat, op, pot, rs, `QWD_DEV_TYPE, tgt};
  endfunction : mk

  task automatic run(input logic [31:0] c);
    int n = 0;
    apb(1'b1, `QWD_CMD_OFS, c, st, err);
    st = 32'h00000001;
    while (st[0] !== 1'b0 && n < 3000) begin
      apb(1'b0, `QWD_STAT_OFS, 32'h00000000, st, err);
      n++;
    end
    chk("busy_end", st[0], 1'b0);
  endtask : run

  task automatic wait_nv();
    int n = 0;
    @(negedge pclk);
    while (nv_busy !== 1'b0 && n < NV_CYC + 10) begin
      @(negedge pclk);
      n++;
    end
    chk("nv_done", nv_busy, 1'b0);
  endtask : wait_nv

  // ----------------------------------------
  // timeout and scenarios
  // ----------------------------------------
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  initial begin
    do_reset();
    settle();
    for (int p = 0; p < 4; p++) begin
      chk("tap_reset", tap_enable[p], 64'h1);
      chk("off_reset", wiper_off[p], 1'b0);
    end
    run(mk(`QWD_OP_WR_WCR, 2'd2, 2'd3, 8'h2A, `QWD_KIND_WRITE, 6'h00));
    chk("ack", st[1], 1'b0);
    settle();
    chk("tap_wr", tap_enable[2], 64'h1 << 42);
    run(mk(`QWD_OP_RD_WCR, 2'd2, 2'd1, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("rd_wcr", st[15:8], 8'h2A);
    run(mk(`QWD_OP_WR_DR, 2'd1, 2'd3, 8'h15, `QWD_KIND_WRITE, 6'h00));
    chk("nv_wr", nv_busy, 1'b1);
    run(mk(`QWD_OP_RD_DR, 2'd1, 2'd3, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("poll", st[1], 1'b1);
    wait_nv();
    run(mk(`QWD_OP_RD_DR, 2'd1, 2'd3, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("rd_dr", st[15:8], 8'h15);
    run(mk(`QWD_OP_XFR_DR_WCR, 2'd1, 2'd3, 8'h00, `QWD_KIND_TWO, 6'h00));
    chk("xfr_static", nv_busy, 1'b0);
    settle();
    chk("tap_xfr", tap_enable[1], 64'h1 << 21);
    run(mk(`QWD_OP_STEP, 2'd1, 2'd0, 8'h00, `QWD_KIND_STEP, {5'd3, 1'b1}));
    settle();
    chk("step_up", tap_enable[1], 64'h1 << 24);
    run(mk(`QWD_OP_STEP, 2'd1, 2'd2, 8'h00, `QWD_KIND_STEP, {5'd5, 1'b0}));
    settle();
    chk("step_dn", tap_enable[1], 64'h1 << 19);
    run(mk(`QWD_OP_XFR_WCR_DR, 2'd2, 2'd1, 8'h00, `QWD_KIND_TWO, 6'h00));
    chk("nv_xfr", nv_busy, 1'b1);
    wait_nv();
    run(mk(`QWD_OP_RD_DR, 2'd2, 2'd1, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("rd_copy", st[15:8], 8'h2A);
    run(mk(`QWD_OP_GXFR_WCR_DR, 2'd0, 2'd2, 8'h00, `QWD_KIND_TWO, 6'h00));
    wait_nv();
    run(mk(`QWD_OP_WR_WCR, 2'd0, 2'd0, 8'h47, `QWD_KIND_WRITE, 6'h00));
    run(mk(`QWD_OP_WR_WCR, 2'd3, 2'd0, 8'h81, `QWD_KIND_WRITE, 6'h00));
    settle();
    chk("off_set", wiper_off[0], 1'b1);
    chk("chain_set", chain_mode[3], 1'b1);
    chk("tap_chain", tap_enable[3], 64'h1 << 1);
    run(mk(`QWD_OP_GXFR_DR_WCR, 2'd3, 2'd2, 8'h00, `QWD_KIND_TWO, 6'h00));
    settle();
    for (int p = 0; p < 4; p++) chk("gload", tap_enable[p], 64'h1 << pos[p]);
    chk("off_clr", wiper_off[0], 1'b0);
    chk("chain_clr", chain_mode[3], 1'b0);
    @(posedge pclk);
    strap_address_pins <= 4'h3;
    run(mk(`QWD_OP_RD_WCR, 2'd2, 2'd0, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("strap_miss", st[1], 1'b1);
    tgt = 4'h3;
    run(mk(`QWD_OP_RD_WCR, 2'd2, 2'd0, 8'h00, `QWD_KIND_READ, 6'h00));
    chk("strap_hit", st[15:8], 8'h2A);
    run(mk(4'h0, 2'd0, 2'd0, 8'h00, `QWD_KIND_TWO, 6'h00));
    chk("bad_op", st[1], 1'b1);
    apb(1'b0, 8'h10, 32'h00000000, st, err);
    chk("unmapped", err, 1'b1);
    do_reset();
    settle();
    chk("repower", tap_enable[2], 64'h1);
    stop_test();
  end
endmodule : quad_wiper_command_decoder_test

//--- qwd_cfg.svh
// constants for the quad wiper command decoder and its bus master
// assumes a 250 MHz pclk on both ends
// Contract
// - instruction byte: opcode, pot bits, reg bits
// - pot bits pick wiper, reg bits pick register
// - four transfer opcodes end after instruction byte
// - register-to-counter copy is static write, settles later
// - counter-to-register copy is timed nonvolatile write
// - global transfers act on all four pots
// - counter and register reads/writes need data byte
// - step mode: clock with data high steps up
// - step mode: clock with data low steps down
// - 1001 reads counter, 1010 writes counter
// - 1011 reads register, 1100 writes register
// - 1101 copies selected register into counter
// - 0001 global load, 1000 global store
// - 0010 enters step mode for selected pot
// - six-bit counter decoded one-hot to 64 taps
// - power-up loads counter from register zero
// - counter is volatile, lost over power loss
// - four stored registers per pot, readable, writable
// - stored-register change finishes within ten milliseconds
// - acknowledge address, instruction and data bytes
// - data byte: position, wiper-off bit, chain bit
// - answer only when address matches strap pins
// - no address acknowledge while write in progress
`ifndef QWD_CFG_SVH
`define QWD_CFG_SVH

`define QWD_CLK_NS 4
`define QWD_SETTLE_NS 100
`define QWD_SETTLE_CYC ((`QWD_SETTLE_NS + `QWD_CLK_NS - 1) / `QWD_CLK_NS)
`define QWD_NV_WRITE_NS 10000000
`define QWD_NV_WRITE_CYC (`QWD_NV_WRITE_NS / `QWD_CLK_NS)
`define QWD_QTR_CYC 8

// device type field, value arbitrary
`define QWD_DEV_TYPE 4'hA
`define QWD_DR_RESET 8'h00

`define QWD_OP_GXFR_DR_WCR 4'h1
`define QWD_OP_STEP 4'h2
`define QWD_OP_GXFR_WCR_DR 4'h8
`define QWD_OP_RD_WCR 4'h9
`define QWD_OP_WR_WCR 4'hA
`define QWD_OP_RD_DR 4'hB
`define QWD_OP_WR_DR 4'hC
`define QWD_OP_XFR_DR_WCR 4'hD
`define QWD_OP_XFR_WCR_DR 4'hE

`define QWD_POS_LSB 0
`define QWD_OFF_BIT 6
`define QWD_CHAIN_BIT 7

`define QWD_CMD_OFS 8'h00
`define QWD_STAT_OFS 8'h04
`define QWD_KIND_TWO 2'h0
`define QWD_KIND_WRITE 2'h1
`define QWD_KIND_READ 2'h2
`define QWD_KIND_STEP 2'h3

`endif

//--- qwd_device.sv
// wiper command decoder: serial slave, counters and stored registers
// assumes pclk much faster than the link clock made by the master
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "qwd_cfg.svh"
module qwd_device #(
  parameter int NV_WRITE_CYCLES = `QWD_NV_WRITE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  qwd_link_if.dev link,
  input wire logic [3:0] strap_address_pins,
  output logic [3:0][63:0] tap_enable,
  output logic [3:0] wiper_off,
  output logic [3:0] chain_mode,
  output logic nv_busy
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [3:0] strap_m;
  logic [3:0] strap_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      strap_m <= 4'h0;
      strap_s <= 4'h0;
    end else begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
      strap_m <= strap_address_pins;
      strap_s <= strap_m;
    end
  end

  logic sclr;
  logic sclf;
  logic start_c;
  logic stop_c;

  assign sclr = scl_s[1] && !scl_s[2];
  assign sclf = !scl_s[1] && scl_s[2];
  assign start_c = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop_c = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] wiper_position_counter [4];
  logic [7:0] dr [4][4];
  logic powerup;
  logic [3:0] pend_mask;
  logic [1:0] pend_rsel;
  logic [7:0] pend_data;
  logic pend_src_wcr;
  logic [21:0] nv_cnt;
  logic [4:0] settle_cnt;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  qwd_pkg::qwd_dev_state_type st;
  qwd_pkg::qwd_dev_state_type pend_st;
  qwd_pkg::qwd_dev_state_type next_st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [3:0] op_q;
  logic [1:0] pot_q;
  logic [1:0] rsel_q;
  logic sda_oe;
  logic ack_now;
  logic byte_eval;
  logic ev_instr;
  logic ev_wdata;
  logic ev_step;
  logic [3:0] op_new;
  logic step_pend;
  logic step_dir;

  assign op_new = shreg[7:4];
  assign byte_eval = sclf && bit_cnt == 4'h8 && (st == qwd_pkg::qwd_st_addr
      || st == qwd_pkg::qwd_st_instr || st == qwd_pkg::qwd_st_wdata);
  assign ev_instr = byte_eval && st == qwd_pkg::qwd_st_instr && ack_now;
  assign ev_wdata = byte_eval && st == qwd_pkg::qwd_st_wdata;
  assign ev_step = sclf && step_pend && st == qwd_pkg::qwd_st_step;
  assign link.sda_dev_oe = sda_oe;

  // step only on a finished high pulse: the stop pulse never falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pend <= 1'b0;
      step_dir <= 1'b0;
    end else if (start_c || stop_c) begin
      step_pend <= 1'b0;
    end else if (sclr && st == qwd_pkg::qwd_st_step) begin
      step_pend <= 1'b1;
      step_dir <= sda_s[1];
    end else if (sclf) begin
      step_pend <= 1'b0;
    end
  end

  always_comb begin
    ack_now = 1'b0;
    next_st = qwd_pkg::qwd_st_idle;
    unique case (st)
      qwd_pkg::qwd_st_addr: begin
        ack_now = shreg[7:4] == `QWD_DEV_TYPE && shreg[3:0] == strap_s
            && !nv_busy;
        next_st = qwd_pkg::qwd_st_instr;
      end
      qwd_pkg::qwd_st_instr: begin
        ack_now = 1'b1;
        case (op_new)
          `QWD_OP_RD_WCR, `QWD_OP_RD_DR: next_st = qwd_pkg::qwd_st_rdata;
          `QWD_OP_WR_WCR, `QWD_OP_WR_DR: next_st = qwd_pkg::qwd_st_wdata;
          `QWD_OP_STEP: next_st = qwd_pkg::qwd_st_step;
          `QWD_OP_GXFR_DR_WCR, `QWD_OP_GXFR_WCR_DR,
          `QWD_OP_XFR_DR_WCR, `QWD_OP_XFR_WCR_DR: next_st = qwd_pkg::qwd_st_idle;
          default: ack_now = 1'b0;
        endcase
      end
      qwd_pkg::qwd_st_wdata: ack_now = 1'b1;
      qwd_pkg::qwd_st_idle, qwd_pkg::qwd_st_rdata, qwd_pkg::qwd_st_step: ack_now = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= qwd_pkg::qwd_st_idle;
      pend_st <= qwd_pkg::qwd_st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      op_q <= 4'h0;
      pot_q <= 2'h0;
      rsel_q <= 2'h0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      st <= qwd_pkg::qwd_st_addr;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st <= qwd_pkg::qwd_st_idle;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      if (sclr && st != qwd_pkg::qwd_st_idle && st != qwd_pkg::qwd_st_step) begin
        if (bit_cnt == 4'h8) begin
          bit_cnt <= 4'h0;
          st <= pend_st;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
          shreg <= {shreg[6:0], sda_s[1]};
        end
      end
      if (sclf) begin
        if (bit_cnt == 4'h8) begin
          if (st == qwd_pkg::qwd_st_rdata) begin
            sda_oe <= 1'b0;
            pend_st <= qwd_pkg::qwd_st_idle;
          end else begin
            sda_oe <= ack_now;
            pend_st <= ack_now ? next_st : qwd_pkg::qwd_st_idle;
          end
          if (ev_instr) begin
            op_q <= op_new;
            pot_q <= shreg[3:2];
            rsel_q <= shreg[1:0];
            tx <= (op_new == `QWD_OP_RD_WCR) ? wiper_position_counter[shreg[3:2]]
                : dr[shreg[3:2]][shreg[1:0]];
          end
        end else if (bit_cnt == 4'h0) begin
          sda_oe <= st == qwd_pkg::qwd_st_rdata && !tx[7];
        end else if (st == qwd_pkg::qwd_st_rdata) begin
          sda_oe <= !tx[3'h7 - bit_cnt[2:0]];
        end
      end
    end
  end

  // ----------------------------------------
  // wiper counters
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerup <= 1'b1;
    end else begin
      powerup <= 1'b0;
    end
  end

  logic wcr_loaded;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcr_loaded <= 1'b0;
    end else begin
      wcr_loaded <= powerup || ev_step || (ev_instr && (op_new == `QWD_OP_XFR_DR_WCR
          || op_new == `QWD_OP_GXFR_DR_WCR)) || (ev_wdata && op_q == `QWD_OP_WR_WCR);
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wiper_position_counter[p] <= 8'h00;
        end else if (powerup) begin
          wiper_position_counter[p] <= dr[p][0];
        end else if (ev_instr && ((op_new == `QWD_OP_XFR_DR_WCR && shreg[3:2] == p)
            || op_new == `QWD_OP_GXFR_DR_WCR)) begin
          wiper_position_counter[p] <= dr[p][shreg[1:0]];
        end else if (ev_wdata && op_q == `QWD_OP_WR_WCR && pot_q == p) begin
          wiper_position_counter[p] <= shreg;
        end else if (ev_step && pot_q == p) begin
          if (step_dir && wiper_position_counter[p][5:0] != 6'h3F) begin
            wiper_position_counter[p][5:0] <= wiper_position_counter[p][5:0] + 6'h01;
          end else if (!step_dir && wiper_position_counter[p][5:0] != 6'h00) begin
            wiper_position_counter[p][5:0] <= wiper_position_counter[p][5:0] - 6'h01;
          end
        end
      end

      // stored registers, written when the frame stops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int r = 0; r < 4; r++) begin
            dr[p][r] <= `QWD_DR_RESET;
          end
        end else if (stop_c && pend_mask[p]) begin
          dr[p][pend_rsel] <= pend_src_wcr ? wiper_position_counter[p] : pend_data;
        end
      end

      // wiper taps follow the counter after settling
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tap_enable[p] <= 64'h0;
          wiper_off[p] <= 1'b1;
          chain_mode[p] <= 1'b0;
        end else if (settle_cnt == 5'h01) begin
          tap_enable[p] <= 64'h1 << wiper_position_counter[p][5:0];
          wiper_off[p] <= wiper_position_counter[p][`QWD_OFF_BIT];
          chain_mode[p] <= wiper_position_counter[p][`QWD_CHAIN_BIT];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // settle and nonvolatile write timers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 5'h00;
    end else if (wcr_loaded) begin
      settle_cnt <= 5'(`QWD_SETTLE_CYC);
    end else if (settle_cnt != 5'h00) begin
      settle_cnt <= settle_cnt - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_mask <= 4'h0;
      pend_rsel <= 2'h0;
      pend_data <= 8'h00;
      pend_src_wcr <= 1'b0;
    end else if (start_c || stop_c) begin
      pend_mask <= 4'h0;
    end else if (ev_instr && op_new == `QWD_OP_XFR_WCR_DR) begin
      pend_mask <= 4'h1 << shreg[3:2];
      pend_rsel <= shreg[1:0];
      pend_src_wcr <= 1'b1;
    end else if (ev_instr && op_new == `QWD_OP_GXFR_WCR_DR) begin
      pend_mask <= 4'hF;
      pend_rsel <= shreg[1:0];
      pend_src_wcr <= 1'b1;
    end else if (ev_wdata && op_q == `QWD_OP_WR_DR) begin
      pend_mask <= 4'h1 << pot_q;
      pend_rsel <= rsel_q;
      pend_data <= shreg;
      pend_src_wcr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_cnt <= 22'h0;
      nv_busy <= 1'b0;
    end else if (stop_c && pend_mask != 4'h0) begin
      nv_cnt <= NV_WRITE_CYCLES[21:0];
      nv_busy <= 1'b1;
    end else if (nv_cnt > 22'h1) begin
      nv_cnt <= nv_cnt - 22'h1;
    end else if (nv_cnt == 22'h1) begin
      nv_cnt <= 22'h0;
      nv_busy <= 1'b0;
    end
  end

endmodule : qwd_device

//--- qwd_host.sv
// bus master for the wiper link, ordered over APB
// assumes APB3 master on pclk; link clock made here by a divider
`timescale 1ns/100ps
`include "qwd_cfg.svh"
module qwd_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  qwd_link_if.host link
);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  qwd_pkg::qwd_host_state_type st;
  logic [7:0] bytes [3];
  logic [1:0] kind;
  logic step_up;
  logic [4:0] steps;
  logic [7:0] rx;
  logic nack;
  logic busy;
  logic mapped;
  logic wr_take;

  assign busy = st != qwd_pkg::qwd_h_idle;
  assign mapped = paddr == `QWD_CMD_OFS || paddr == `QWD_STAT_OFS;
  assign wr_take = psel && penable && pready && pwrite && paddr == `QWD_CMD_OFS && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pwrite && paddr == `QWD_STAT_OFS)
          ? {16'h0, rx, 6'h0, nack, busy} : 32'h0;
    end
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  logic [1:0] sda_s;
  logic [3:0] qcnt;
  logic tick;
  logic [1:0] phase;
  logic [1:0] byte_i;
  logic [3:0] bit_i;
  logic reading;
  logic [7:0] cur;

  assign tick = qcnt == 4'h0;
  assign reading = kind == `QWD_KIND_READ && byte_i == 2'h2;
  assign cur = bytes[byte_i];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s <= 2'h3;
      qcnt <= 4'h0;
    end else begin
      sda_s <= {sda_s[0], link.sda};
      qcnt <= (tick || !busy) ? 4'(`QWD_QTR_CYC - 1) : qcnt - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= qwd_pkg::qwd_h_idle;
      for (int i = 0; i < 3; i++) begin
        bytes[i] <= 8'h00;
      end
      kind <= `QWD_KIND_TWO;
      step_up <= 1'b0;
      steps <= 5'h00;
      rx <= 8'h00;
      nack <= 1'b0;
      phase <= 2'h0;
      byte_i <= 2'h0;
      bit_i <= 4'h0;
      link.scl <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end else if (wr_take) begin
      bytes[0] <= pwdata[7:0];
      bytes[1] <= pwdata[15:8];
      bytes[2] <= pwdata[23:16];
      kind <= pwdata[25:24];
      step_up <= pwdata[26];
      steps <= pwdata[31:27];
      nack <= 1'b0;
      phase <= 2'h0;
      byte_i <= 2'h0;
      bit_i <= 4'h0;
      st <= qwd_pkg::qwd_h_start;
    end else if (busy && tick) begin
      phase <= phase + 2'h1;
      unique case (st)
        qwd_pkg::qwd_h_start: begin
          case (phase)
            2'h0: link.sda_host_oe <= 1'b0;
            2'h1: link.scl <= 1'b1;
            2'h2: link.sda_host_oe <= 1'b1;
            default: begin
              link.scl <= 1'b0;
              st <= qwd_pkg::qwd_h_bit;
            end
          endcase
        end
        qwd_pkg::qwd_h_bit: begin
          case (phase)
            2'h0: link.sda_host_oe <= bit_i != 4'h8 && !reading
                && !cur[3'h7 - bit_i[2:0]];
            2'h1: link.scl <= 1'b1;
            2'h2: begin
              if (bit_i != 4'h8 && reading) begin
                rx <= {rx[6:0], sda_s[1]};
              end else if (bit_i == 4'h8 && !reading && sda_s[1]) begin
                nack <= 1'b1;
              end
            end
            default: begin
              link.scl <= 1'b0;
              bit_i <= (bit_i == 4'h8) ? 4'h0 : bit_i + 4'h1;
              if (bit_i == 4'h8) begin
                if (nack || byte_i == 2'h2 || (byte_i == 2'h1 && kind == `QWD_KIND_TWO)) begin
                  st <= qwd_pkg::qwd_h_stop;
                end else if (byte_i == 2'h1 && kind == `QWD_KIND_STEP) begin
                  st <= (steps == 5'h00) ? qwd_pkg::qwd_h_stop : qwd_pkg::qwd_h_step;
                end else begin
                  byte_i <= byte_i + 2'h1;
                end
              end
            end
          endcase
        end
        qwd_pkg::qwd_h_step: begin
          case (phase)
            2'h0: link.sda_host_oe <= !step_up;
            2'h1: link.scl <= 1'b1;
            2'h2: link.scl <= 1'b1;
            default: begin
              link.scl <= 1'b0;
              steps <= steps - 5'h01;
              if (steps == 5'h01) begin
                st <= qwd_pkg::qwd_h_stop;
              end
            end
          endcase
        end
        qwd_pkg::qwd_h_stop: begin
          case (phase)
            2'h0: link.sda_host_oe <= 1'b1;
            2'h1: link.scl <= 1'b1;
            2'h2: link.sda_host_oe <= 1'b0;
            default: st <= qwd_pkg::qwd_h_idle;
          endcase
        end
        qwd_pkg::qwd_h_idle: begin
          link.scl <= 1'b1;
        end
      endcase
    end
  end

endmodule : qwd_host

//--- qwd_link_asserts.sv
// concurrent checks on the two-wire link between bus master and decoder
// assumes the bench instantiates it beside the link interface
`timescale 1ns/100ps
module qwd_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_scl_high_min;
    $rose(scl) |=> scl [*8];
  endproperty
  a_scl_high_min: assert property (p_scl_high_min)
    else $error("link clock high phase too short");

  property p_scl_low_min;
    $fell(scl) |=> !scl [*8];
  endproperty
  a_scl_low_min: assert property (p_scl_low_min)
    else $error("link clock low phase too short");

  property p_dev_change_low;
    $changed(sda_dev_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_change_low: assert property (p_dev_change_low)
    else $error("device moved data while link clock high");

  property p_dev_release;
    $rose(sda_dev_oe) |-> ##[1:400] !sda_dev_oe;
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device held data line too long");

  property p_reset_idle;
    $rose(presetn) |-> scl && !sda_host_oe && !sda_dev_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");

  property p_stop_idle;
    $rose(sda) && scl && $past(scl) |=> scl [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("link clock moved right after stop");

  property p_start_by_host;
    $fell(sda) && scl && $past(scl) |-> sda_host_oe && !sda_dev_oe;
  endproperty
  a_start_by_host: assert property (p_start_by_host)
    else $error("start not made by master");

  property p_no_contention;
    sda_dev_oe && scl |-> !sda_host_oe;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("master drove data while device answered");
endmodule : qwd_link_asserts

//--- qwd_link_if.sv
// two-wire link between bus master and wiper decoder
// assumes an external pull-up: the data line is low while either end drives
`timescale 1ns/100ps
interface qwd_link_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;

  assign sda = !(sda_host_oe || sda_dev_oe);

  modport host (output scl, output sda_host_oe, input sda);
  modport dev (input scl, input sda, output sda_dev_oe);

endinterface : qwd_link_if

//--- qwd_pkg.sv
// state types shared by both ends of the wiper link
// assumes nothing beyond a SystemVerilog tool
package qwd_pkg;

  typedef enum logic [5:0] {
    qwd_st_idle = 6'h01,
    qwd_st_addr = 6'h02,
    qwd_st_instr = 6'h04,
    qwd_st_wdata = 6'h08,
    qwd_st_rdata = 6'h10,
    qwd_st_step = 6'h20
  } qwd_dev_state_type;

  typedef enum logic [4:0] {
    qwd_h_idle = 5'h01,
    qwd_h_start = 5'h02,
    qwd_h_bit = 5'h04,
    qwd_h_step = 5'h08,
    qwd_h_stop = 5'h10
  } qwd_host_state_type;

endpackage : qwd_pkg
